/* cmon_regs.svh */
`ifndef CMON_REGS_SVH
`define CMON_REGS_SVH
// byte counts of each register group
`define CMON_CFG_BYTES   5'h06
`define CMON_CV_BYTES    5'h12
`define CMON_CV_BYTES10  5'h0F
`define CMON_FLG_BYTES   5'h03
`define CMON_TMP_BYTES   5'h05
`define CMON_DGN_BYTES   5'h02
// byte index of the group byte that holds the thermal shutdown bit
`define CMON_TMP_THERMAL_SHUTDOWN_FLAG_IDX 5'h04
// configuration byte 0 bit positions
`define CMON_CFG0_WDT    7
`define CMON_CFG0_GPIO2  6
`define CMON_CFG0_GPIO1  5
`define CMON_CFG0_LEVEL_POLL_BIT  4
`define CMON_CFG0_TEN_CELL_SELECT 3
// reset values
`define CMON_RST_CDC     3'h0
`define CMON_RST_GPIO    1'h1
`define CMON_RST_CELLS   12'h000
`define CMON_RST_THRESH  8'h00
`define CMON_RST_RESULT  12'h000
// comparator periods in ms
`define CMON_PER_NONE    12'h000
`define CMON_PER_13MS    12'h00D
`define CMON_PER_130MS   12'h082
`define CMON_PER_500MS   12'h1F4
`define CMON_PER_2000MS  12'h7D0
// result scaling, in 1.5 mV steps
`define CMON_RES_OFFSET  14'sh0200
`define CMON_UV_OFFSET   14'sh001F
`define CMON_OV_OFFSET   14'sh0020
`define CMON_THR_SHIFT   4
`define CMON_RES_BUSY    12'hFFF
// result select codes on the conversion side
`define CMON_SEL_ETMP1   4'hC
`define CMON_SEL_ETMP2   4'hD
`define CMON_SEL_INTERNAL_TEMP_RESULT    4'hE
`define CMON_SEL_REF     4'hF
`endif

/* cmon_pkg.sv */
package cmon_pkg;
	typedef enum logic [2:0] {
		CMON_GRP_CFG,
		CMON_GRP_CV,
		CMON_GRP_FLG,
		CMON_GRP_TMP,
		CMON_GRP_DGN
	} cmon_grp_t;
	typedef logic [11:0] cmon_result_t;
endpackage

/* cmon_regbank.sv */
// Functional notes
// - comparator duty field sets comparator on/off, period and reference power-down
// - cell-count select 0 gives twelve cells, 1 gives ten cells
// - polling select 0 gives toggle polling, 1 gives level polling
// - general-pin bit written 0 enables pull-down, 1 disables it, default off
// - general-pin bit reads present pin level, never the written setting
// - watchdog status bit reads present watchdog output pin level
// - each cell discharge bit 1 turns shorting switch on, default off
// - undervoltage level is (code-31)*16 steps, code defaults to zero
// - overvoltage level is (code-32)*16 steps, code defaults to zero
// - mask bit 1 disables cell interrupts and clears its flags
// - cell result 12 bits, offset 512, reads all ones while converting
// - while comparator runs, undervoltage flag set when cell is below undervoltage level, else zero
// - while comparator runs, overvoltage flag set when cell is above overvoltage level, else zero
// - external temperature results are 12-bit offset-512 values
// - internal temperature result is 12-bit offset-512 value
// - diagnostic reference: low byte first register, high nibble second register
// - diagnostic reference is offset-512 scaled; processor judges its range
// - second diagnostic register: revision bits 7:6, mux fault bit 5, bit 4 zero
// - ten-cell mode holds flags of cells 11 and 12 low
// - results of cells 11 and 12 readable only in twelve-cell mode
`timescale 1ns/1ns
`default_nettype none
`include "cmon_regs.svh"
module cmon_regbank
	import cmon_pkg::*;
#(
	parameter int          NCELL    = 12,
	parameter logic [1:0]  REVISION = 2'h0  // arbitrary value
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             nrst,
	// register access from the serial front end
	input  wire cmon_grp_t        reg_grp,
	input  wire logic [4:0]       reg_idx,
	input  wire logic             reg_wr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	output logic                  reg_rvalid,
	// conversion results
	input  wire logic             res_wr,
	input  wire logic [3:0]       res_sel,
	input  wire cmon_result_t     res_val,
	input  wire logic             res_mux_fault,
	input  wire logic             conv_busy,
	input  wire logic             thermal_event,
	// pin levels
	input  wire logic             gpio1_level,
	input  wire logic             gpio2_level,
	input  wire logic             watchdog_level,
	// controls to the analog side
	output logic                  gpio1_pd_en,
	output logic                  gpio2_pd_en,
	output logic [NCELL-1:0]      discharge_en,
	output logic                  ten_cell_mode,
	output logic                  level_poll_mode,
	output logic                  comparator_on,
	output logic                  ref_power_down,
	output logic                  standby_mode,
	output logic [11:0]           comparator_period_ms,
	output logic                  any_cell_flag
);
	logic [2:0]         cdc_q, cdc_d;
	logic               ten_cell_select_q, ten_cell_select_d, level_poll_bit_q, level_poll_bit_d;
	logic               gp1_q, gp1_d, gp2_q, gp2_d;
	logic [NCELL-1:0]   dcc_q, dcc_d, mask_q, mask_d;
	logic [7:0]         vuv_q, vuv_d, vov_q, vov_d;
	cmon_result_t       cv_q [NCELL], cv_d [NCELL];
	cmon_result_t       et1_q, et1_d, et2_q, et2_d, internal_temp_result_q, internal_temp_result_d, ref_q, ref_d;
	logic               muxf_q, muxf_d, thermal_shutdown_flag_q, thermal_shutdown_flag_d;
	logic [NCELL-1:0]   uvf_q, uvf_d, ovf_q, ovf_d;
	logic [NCELL-1:0]   uv_hit, ov_hit;
	logic [7:0]         rdata_d;
	logic               cmp_on_d, refpd_d, stby_d;
	logic [11:0]        per_d;
	logic signed [13:0] uv_lvl, ov_lvl;
	logic               cfg_wr;
	assign cfg_wr = reg_wr && (reg_grp == CMON_GRP_CFG);
	// thresholds in 1.5 mV steps relative to zero volts
	assign uv_lvl = (($signed({6'h00, vuv_q}) - `CMON_UV_OFFSET) <<< `CMON_THR_SHIFT);
	assign ov_lvl = (($signed({6'h00, vov_q}) - `CMON_OV_OFFSET) <<< `CMON_THR_SHIFT);
	// per-cell comparison against the incoming result
	for (genvar i = 0; i < NCELL; i++) begin : g_cmp
		logic signed [13:0] v;
		assign v         = $signed({2'h0, res_val}) - `CMON_RES_OFFSET;
		assign uv_hit[i] = v < uv_lvl;
		assign ov_hit[i] = v > ov_lvl;
	end
	// pairs of 12-bit values packed into three bytes
	function automatic logic [7:0] pack3(input cmon_result_t a, input cmon_result_t b,
		input logic [1:0] sub);
		unique case (sub)
			2'h0:    pack3 = a[7:0];
			2'h1:    pack3 = {b[3:0], a[11:8]};
			default: pack3 = b[11:4];
		endcase
	endfunction
	always_comb begin
		cdc_d    = cdc_q;
		ten_cell_select_d = ten_cell_select_q;
		level_poll_bit_d  = level_poll_bit_q;
		gp1_d    = gp1_q;
		gp2_d    = gp2_q;
		dcc_d    = dcc_q;
		mask_d   = mask_q;
		vuv_d    = vuv_q;
		vov_d    = vov_q;
		cv_d     = cv_q;
		et1_d    = et1_q;
		et2_d    = et2_q;
		internal_temp_result_d   = internal_temp_result_q;
		ref_d    = ref_q;
		muxf_d   = muxf_q;
		uvf_d    = uvf_q;
		ovf_d    = ovf_q;
		// only the configuration group takes writes; everything else is read-only
		if (cfg_wr) begin
			unique case (reg_idx)
				5'h00: begin
					cdc_d    = reg_wdata[2:0];
					ten_cell_select_d = reg_wdata[`CMON_CFG0_TEN_CELL_SELECT];
					level_poll_bit_d  = reg_wdata[`CMON_CFG0_LEVEL_POLL_BIT];
					gp1_d    = reg_wdata[`CMON_CFG0_GPIO1];
					gp2_d    = reg_wdata[`CMON_CFG0_GPIO2];
				end
				5'h01: dcc_d[7:0] = reg_wdata;
				5'h02: begin
					dcc_d[11:8] = reg_wdata[3:0];
					mask_d[3:0] = reg_wdata[7:4];
				end
				5'h03: mask_d[11:4] = reg_wdata;
				5'h04: vuv_d = reg_wdata;
				5'h05: vov_d = reg_wdata;
				default: ;
			endcase
		end
		if (res_wr) begin
			unique case (res_sel)
				`CMON_SEL_ETMP1: et1_d = res_val;
				`CMON_SEL_ETMP2: et2_d = res_val;
				`CMON_SEL_INTERNAL_TEMP_RESULT:  internal_temp_result_d = res_val;
				`CMON_SEL_REF: begin
					ref_d  = res_val;
					muxf_d = res_mux_fault;
				end
				default: begin
					cv_d[res_sel] = res_val;
					// flags follow the latest comparison only while the comparator runs
					if (cdc_q > 3'h1) begin
						uvf_d[res_sel] = uv_hit[res_sel];
						ovf_d[res_sel] = ov_hit[res_sel];
					end
				end
			endcase
		end
		uvf_d = uvf_d & ~mask_d;
		ovf_d = ovf_d & ~mask_d;
		if (ten_cell_select_d) begin
			uvf_d[11:10] = 2'h0;
			ovf_d[11:10] = 2'h0;
		end
	end
	// set wins over the read clear so an event is never lost
	always_comb begin
		thermal_shutdown_flag_d = thermal_shutdown_flag_q;
		if (reg_rd && reg_grp == CMON_GRP_TMP && reg_idx == `CMON_TMP_THERMAL_SHUTDOWN_FLAG_IDX)
			thermal_shutdown_flag_d = 1'b0;
		if (thermal_event)
			thermal_shutdown_flag_d = 1'b1;
	end
	always_comb begin
		cmp_on_d = cdc_d > 3'h1;
		refpd_d  = cdc_d == 3'h0 || cdc_d > 3'h4;
		stby_d   = cdc_d == 3'h0;
		unique case (cdc_d)
			3'h0, 3'h1: per_d = `CMON_PER_NONE;
			3'h2:       per_d = `CMON_PER_13MS;
			3'h3, 3'h5: per_d = `CMON_PER_130MS;
			3'h4, 3'h6: per_d = `CMON_PER_500MS;
			3'h7:       per_d = `CMON_PER_2000MS;
		endcase
	end
	always_comb begin
		logic [3:0] pr;
		logic [1:0] sub;
		pr      = 4'(reg_idx / 5'h03);
		sub     = 2'(reg_idx % 5'h03);
		rdata_d = 8'h00;
		unique case (reg_grp)
			CMON_GRP_CFG: begin
				unique case (reg_idx)
					5'h00: rdata_d = {watchdog_level, gpio2_level, gpio1_level,
						level_poll_bit_q, ten_cell_select_q, cdc_q};
					5'h01: rdata_d = dcc_q[7:0];
					5'h02: rdata_d = {mask_q[3:0], dcc_q[11:8]};
					5'h03: rdata_d = mask_q[11:4];
					5'h04: rdata_d = vuv_q;
					5'h05: rdata_d = vov_q;
					default: ;
				endcase
			end
			CMON_GRP_CV: begin
				// last pair is cut off in ten-cell mode
				if (reg_idx < (ten_cell_select_q ? `CMON_CV_BYTES10 : `CMON_CV_BYTES)) begin
					if (conv_busy)
						rdata_d = pack3(`CMON_RES_BUSY, `CMON_RES_BUSY, sub);
					else
						rdata_d = pack3(cv_q[2*pr], cv_q[2*pr+1], sub);
				end
			end
			CMON_GRP_FLG: begin
				if (reg_idx < `CMON_FLG_BYTES) begin
					for (int k = 0; k < 4; k++) begin
						rdata_d[2*k]   = uvf_q[4*reg_idx+k];
						rdata_d[2*k+1] = ovf_q[4*reg_idx+k];
					end
				end
			end
			CMON_GRP_TMP: begin
				if (reg_idx < 5'h03)
					rdata_d = pack3(et1_q, et2_q, sub);
				else if (reg_idx == 5'h03)
					rdata_d = internal_temp_result_q[7:0];
				else if (reg_idx == `CMON_TMP_THERMAL_SHUTDOWN_FLAG_IDX)
					rdata_d = {3'h0, thermal_shutdown_flag_q, internal_temp_result_q[11:8]};
			end
			CMON_GRP_DGN: begin
				if (reg_idx == 5'h00)
					rdata_d = ref_q[7:0];
				else if (reg_idx == 5'h01)
					rdata_d = {REVISION, muxf_q, 1'b0, ref_q[11:8]};
			end
			default: ;
		endcase
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cdc_q                <= `CMON_RST_CDC;
			ten_cell_select_q             <= 1'b0;
			level_poll_bit_q              <= 1'b0;
			gp1_q                <= `CMON_RST_GPIO;
			gp2_q                <= `CMON_RST_GPIO;
			dcc_q                <= `CMON_RST_CELLS;
			mask_q               <= `CMON_RST_CELLS;
			vuv_q                <= `CMON_RST_THRESH;
			vov_q                <= `CMON_RST_THRESH;
			cv_q                 <= '{default: `CMON_RST_RESULT};
			et1_q                <= `CMON_RST_RESULT;
			et2_q                <= `CMON_RST_RESULT;
			internal_temp_result_q               <= `CMON_RST_RESULT;
			ref_q                <= `CMON_RST_RESULT;
			muxf_q               <= 1'b0;
			thermal_shutdown_flag_q               <= 1'b0;
			uvf_q                <= `CMON_RST_CELLS;
			ovf_q                <= `CMON_RST_CELLS;
			reg_rdata            <= 8'h00;
			reg_rvalid           <= 1'b0;
			comparator_on        <= 1'b0;
			ref_power_down       <= 1'b1;
			standby_mode         <= 1'b1;
			comparator_period_ms <= `CMON_PER_NONE;
		end else begin
			cdc_q                <= cdc_d;
			ten_cell_select_q             <= ten_cell_select_d;
			level_poll_bit_q              <= level_poll_bit_d;
			gp1_q                <= gp1_d;
			gp2_q                <= gp2_d;
			dcc_q                <= dcc_d;
			mask_q               <= mask_d;
			vuv_q                <= vuv_d;
			vov_q                <= vov_d;
			cv_q                 <= cv_d;
			et1_q                <= et1_d;
			et2_q                <= et2_d;
			internal_temp_result_q               <= internal_temp_result_d;
			ref_q                <= ref_d;
			muxf_q               <= muxf_d;
			thermal_shutdown_flag_q               <= thermal_shutdown_flag_d;
			uvf_q                <= uvf_d;
			ovf_q                <= ovf_d;
			if (reg_rd)
				reg_rdata <= rdata_d;
			reg_rvalid           <= reg_rd;
			comparator_on        <= cmp_on_d;
			ref_power_down       <= refpd_d;
			standby_mode         <= stby_d;
			comparator_period_ms <= per_d;
		end
	end
	assign gpio1_pd_en     = ~gp1_q;
	assign gpio2_pd_en     = ~gp2_q;
	assign discharge_en    = dcc_q;
	assign ten_cell_mode   = ten_cell_select_q;
	assign level_poll_mode = level_poll_bit_q;
	assign any_cell_flag   = |(uvf_q | ovf_q);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	a_gpio_readback: assert property (reg_rd && reg_grp == CMON_GRP_CFG && reg_idx == 5'h00
		|=> reg_rdata[`CMON_CFG0_GPIO1] == $past(gpio1_level)
			&& reg_rdata[`CMON_CFG0_WDT] == $past(watchdog_level))
		else $error("config byte 0 does not show pin levels");
	a_pulldown_write: assert property (cfg_wr && reg_idx == 5'h00
		|=> gpio2_pd_en == !$past(reg_wdata[`CMON_CFG0_GPIO2]))
		else $error("pull-down does not follow write");
	a_mask_clears: assert property (mask_q[0] |-> !uvf_q[0] && !ovf_q[0])
		else $error("masked cell has a flag");
	a_ten_cell_flags: assert property (ten_cell_select_q |-> uvf_q[11:10] == 2'h0
		&& ovf_q[11:10] == 2'h0)
		else $error("cell 11 or 12 flag set in ten-cell mode");
	a_busy_ones: assert property (reg_rd && reg_grp == CMON_GRP_CV && conv_busy
		&& reg_idx == 5'h00 |=> reg_rdata == 8'hFF && reg_rvalid)
		else $error("busy cell read not all ones");
	a_thermal_shutdown_flag_clear: assert property (thermal_shutdown_flag_q && reg_rd && reg_grp == CMON_GRP_TMP
		&& reg_idx == `CMON_TMP_THERMAL_SHUTDOWN_FLAG_IDX |=> thermal_shutdown_flag_q == $past(thermal_event))
		else $error("thermal shutdown bit not cleared by read");
	a_diag_readonly: assert property (reg_wr && reg_grp == CMON_GRP_DGN && !res_wr
		|=> $stable(ref_q))
		else $error("diagnostic value changed by write");
	a_uv_flag_set: assert property (res_wr && res_sel == 4'h0 && cdc_q > 3'h1 && !mask_d[0]
		&& !cfg_wr |=> uvf_q[0] == $past(uv_hit[0]))
		else $error("undervoltage flag does not follow comparison");
	a_standby_decode: assert property ((cdc_q == 3'h0 && !cfg_wr) [*2] |-> standby_mode
		&& !comparator_on && ref_power_down)
		else $error("duty code 0 is not standby");
	a_cv_hidden: assert property (reg_rd && reg_grp == CMON_GRP_CV && ten_cell_select_q
		&& reg_idx == 5'h0F |=> reg_rdata == 8'h00)
		else $error("cell 11 result readable in ten-cell mode");
endmodule
`default_nettype wire

/* cmon_host.sv */
`timescale 1ns/1ns
`default_nettype none
module cmon_host
	import cmon_pkg::*;
(
	// clock
	input  wire logic      mclk,
	// register port toward the bank
	output var cmon_grp_t  reg_grp,
	output var logic [4:0] reg_idx,
	output var logic       reg_wr,
	output var logic [7:0] reg_wdata,
	output var logic       reg_rd
);
	initial begin
		reg_grp = CMON_GRP_CFG;
		reg_idx = 5'h00;
		reg_wr = 1'h0;
		reg_wdata = 8'h00;
		reg_rd = 1'h0;
	end

	// strobes live one full cycle, launched and dropped on the falling edge
	task automatic wr(input cmon_grp_t g, input logic [4:0] i, input logic [7:0] d);
		@(negedge mclk);
		reg_grp <= g;
		reg_idx <= i;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(negedge mclk);
		reg_wr <= 1'h0;
	endtask

	// data bytes are treated as unsigned fields, never sign extended
	task automatic rd(input cmon_grp_t g, input logic [4:0] i);
		@(negedge mclk);
		reg_grp <= g;
		reg_idx <= i;
		reg_rd <= 1'h1;
		@(negedge mclk);
		reg_rd <= 1'h0;
	endtask
endmodule
`default_nettype wire

/* cmon_regbank_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cmon_regs.svh"
module cmon_regbank_tb import cmon_pkg::*;;
	logic mclk = 1'h0, nrst = 1'h0;
	cmon_grp_t grp;
	logic [4:0] idx;
	logic wr, rd, rvalid, res_wr, mux_f, busy, thev, g1, g2, wd;
	logic [7:0] wdata, rdata;
	logic [3:0] res_sel;
	cmon_result_t res_val, c11, e1, e2, it, rf;
	logic g1pd, g2pd, ten, lvl, con, rpd, stby, anyf;
	logic [11:0] dis, per, r;
	logic [11:0] pt[8];
	int n_fail, n_compared;
	logic [7:0] exp_q[$];

	cmon_host i_cmon_host(.mclk(mclk), .reg_grp(grp), .reg_idx(idx), .reg_wr(wr),
		.reg_wdata(wdata), .reg_rd(rd));
	cmon_regbank #(.REVISION(2'h2)) i_cmon_regbank(.mclk(mclk), .nrst(nrst),
		.reg_grp(grp), .reg_idx(idx), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
		.reg_rdata(rdata), .reg_rvalid(rvalid), .res_wr(res_wr), .res_sel(res_sel),
		.res_val(res_val), .res_mux_fault(mux_f), .conv_busy(busy),
		.thermal_event(thev), .gpio1_level(g1), .gpio2_level(g2), .watchdog_level(wd),
		.gpio1_pd_en(g1pd), .gpio2_pd_en(g2pd), .discharge_en(dis), .ten_cell_mode(ten),
		.level_poll_mode(lvl), .comparator_on(con), .ref_power_down(rpd),
		.standby_mode(stby), .comparator_period_ms(per), .any_cell_flag(anyf));

	always #25 mclk = ~mclk;

	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic rdx(input cmon_grp_t g, input logic [4:0] i, input logic [7:0] e);
		exp_q.push_back(e);
		i_cmon_host.rd(g, i);
	endtask

	task automatic ld(input logic [3:0] s, input cmon_result_t v);
		@(negedge mclk);
		res_sel <= s;
		res_val <= v;
		res_wr <= 1'h1;
		@(negedge mclk);
		res_wr <= 1'h0;
	endtask

	// read answers are paired with the oldest noted expectation
	always @(negedge mclk) begin
		if (nrst && rvalid === 1'h1) begin
			if (exp_q.size() == 0)
				chk("unexpected read", 12'h000, 12'h001);
			else
				chk("rdata", rdata, exp_q.pop_front());
		end
	end

	initial begin
		#2500000;
		chk("timeout", 12'h000, 12'h001);
		wrap_up();
	end

	initial begin
		{res_wr, res_sel, res_val, mux_f, busy, thev} = '0;
		{g1, g2, wd} = 3'h5;
		pt = '{`CMON_PER_NONE, `CMON_PER_NONE, `CMON_PER_13MS, `CMON_PER_130MS,
			`CMON_PER_500MS, `CMON_PER_130MS, `CMON_PER_500MS, `CMON_PER_2000MS};
		void'($urandom(32'h0266));
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		nrst <= 1'h1;
		@(negedge mclk);
		chk("pd1 reset", g1pd, 12'h000);
		chk("standby reset", stby, 12'h001);
		chk("discharge reset", dis, 12'h000);
		chk("ten reset", ten, 12'h000);
		chk("poll reset", lvl, 12'h000);
		rdx(CMON_GRP_CFG, 5'h00, 8'hA0);
		for (int d = 0; d < 8; d++) begin
			i_cmon_host.wr(CMON_GRP_CFG, 5'h00, 8'(d));
			repeat (2) @(negedge mclk);
			chk("comparator on", con, 12'(d > 1));
			chk("ref down", rpd, 12'(d == 0 || d > 4));
			chk("standby", stby, 12'(d == 0));
			chk("period", per, pt[d]);
			chk("pd2 on", g2pd, 12'h001);
			chk("pd1 on", g1pd, 12'h001);
		end
		i_cmon_host.wr(CMON_GRP_CFG, 5'h00, 8'h7A);
		{wd, g2, g1} = 3'($urandom);
		repeat (2) @(negedge mclk);
		chk("pd1 off", g1pd, 12'h000);
		chk("ten set", ten, 12'h001);
		chk("poll set", lvl, 12'h001);
		rdx(CMON_GRP_CFG, 5'h00, {wd, g2, g1, 5'h1A});
		r = 12'($urandom);
		i_cmon_host.wr(CMON_GRP_CFG, 5'h01, r[7:0]);
		i_cmon_host.wr(CMON_GRP_CFG, 5'h02, {4'h0, r[11:8]});
		@(negedge mclk);
		chk("discharge", dis, r);
		i_cmon_host.wr(CMON_GRP_CFG, 5'h04, 8'h40);
		i_cmon_host.wr(CMON_GRP_CFG, 5'h05, 8'h80);
		rdx(CMON_GRP_CFG, 5'h01, r[7:0]);
		rdx(CMON_GRP_CFG, 5'h02, {4'h0, r[11:8]});
		rdx(CMON_GRP_CFG, 5'h04, 8'h40);
		rdx(CMON_GRP_CFG, 5'h05, 8'h80);
		c11 = 12'h410 + 12'($urandom % 1000);
		ld(4'h0, 12'h40F);
		ld(4'h1, 12'h410);
		ld(4'h2, 12'h801);
		ld(4'h3, 12'h800);
		ld(4'hA, c11);
		ld(4'hB, 12'hFFF);
		rdx(CMON_GRP_FLG, 5'h00, 8'h21);
		rdx(CMON_GRP_FLG, 5'h02, 8'h00);
		chk("any flag", anyf, 12'h001);
		i_cmon_host.wr(CMON_GRP_CFG, 5'h02, {4'h1, r[11:8]});
		rdx(CMON_GRP_FLG, 5'h00, 8'h20);
		i_cmon_host.wr(CMON_GRP_CFG, 5'h02, {4'hF, r[11:8]});
		i_cmon_host.wr(CMON_GRP_CFG, 5'h03, 8'hFF);
		@(negedge mclk);
		chk("all masked", anyf, 12'h000);
		rdx(CMON_GRP_CV, 5'h00, 8'h0F);
		rdx(CMON_GRP_CV, 5'h01, 8'h04);
		rdx(CMON_GRP_CV, 5'h02, 8'h41);
		rdx(CMON_GRP_CV, 5'h0F, 8'h00);
		i_cmon_host.wr(CMON_GRP_CFG, 5'h00, 8'h72);
		rdx(CMON_GRP_CV, 5'h0F, c11[7:0]);
		busy = 1'h1;
		rdx(CMON_GRP_CV, 5'h00, 8'hFF);
		@(negedge mclk);
		busy = 1'h0;
		e1 = 12'($urandom);
		e2 = 12'($urandom);
		it = 12'($urandom);
		ld(4'hC, e1);
		ld(4'hD, e2);
		ld(4'hE, it);
		thev = 1'h1;
		@(negedge mclk);
		thev = 1'h0;
		rdx(CMON_GRP_TMP, 5'h00, e1[7:0]);
		rdx(CMON_GRP_TMP, 5'h01, {e2[3:0], e1[11:8]});
		rdx(CMON_GRP_TMP, 5'h02, e2[11:4]);
		rdx(CMON_GRP_TMP, 5'h03, it[7:0]);
		rdx(CMON_GRP_TMP, 5'h04, {4'h1, it[11:8]});
		rdx(CMON_GRP_TMP, 5'h04, {4'h0, it[11:8]});
		rf = 12'($urandom);
		mux_f = 1'h1;
		ld(4'hF, rf);
		i_cmon_host.wr(CMON_GRP_DGN, 5'h01, 8'h00);
		rdx(CMON_GRP_DGN, 5'h00, rf[7:0]);
		rdx(CMON_GRP_DGN, 5'h01, {4'hA, rf[11:8]});
		// mid-run reset: controls and stored results go back to their reset values
		nrst <= 1'h0;
		repeat (2) @(negedge mclk);
		chk("discharge mid reset", dis, 12'h000);
		chk("standby mid reset", stby, 12'h001);
		chk("flags mid reset", anyf, 12'h000);
		nrst <= 1'h1;
		rdx(CMON_GRP_DGN, 5'h00, 8'h00);
		for (int k = 0; k < 20 && exp_q.size() > 0; k++)
			@(negedge mclk);
		if (exp_q.size() > 0)
			chk("reads answered", 12'(exp_q.size()), 12'h000);
		wrap_up();
	end
endmodule
`default_nettype wire
